//--- cap_source.sv
`timescale 1ns/100ps
`default_nettype none
module cap_source
   import capture_pkg::*;
(
   input  wire logic              clk,
   output var  logic [NUM_CH-1:0] cap_pin
);
   // Pins idle low; the source never leaves a line floating
   initial begin
      cap_pin = '0;
   end

   // One rise and one fall, each held long enough to pass the synchroniser
   task automatic pulse(input int ch);
      @(posedge clk);
      cap_pin[ch] <= 1'b1;
      repeat (4) @(posedge clk);
      cap_pin[ch] <= 1'b0;
      repeat (6) @(posedge clk);
   endtask
endmodule
`default_nettype wire

//--- capture_pkg.sv
package capture_pkg;
   // Geometry
   localparam int NUM_CH     = 8;
   localparam int FIFO_DEPTH = 4;
   localparam int DATA_W     = 16;
   localparam int CNT_W      = 3;

   // APB byte offsets
   localparam logic [7:0] CTRL_BASE = 8'h00;
   localparam logic [7:0] BUF_BASE  = 8'h20;
   localparam logic [7:0] IFS_OFS   = 8'h40;
   localparam logic [7:0] IEC_OFS   = 8'h44;

   // Field positions in channel_control_reg
   localparam int MODE_LSB  = 0;
   localparam int BFNE_BIT  = 3;
   localparam int OVF_BIT   = 4;
   localparam int EPI_LSB   = 5;
   localparam int TBSEL_BIT = 7;
   localparam int SIDL_BIT  = 13;

   // Reset values
   localparam logic       TBSEL_RST = 1'b1;
   localparam logic [2:0] MODE_RST  = 3'h0;
   localparam logic [1:0] EPI_RST   = 2'h0;

   // Capture modes
   localparam logic [2:0] MODE_OFF      = 3'h0;
   localparam logic [2:0] MODE_EVERY    = 3'h1;
   localparam logic [2:0] MODE_FALL     = 3'h2;
   localparam logic [2:0] MODE_RISE     = 3'h3;
   localparam logic [2:0] MODE_RISE4    = 3'h4;
   localparam logic [2:0] MODE_RISE16   = 3'h5;
   localparam logic [2:0] MODE_INT_ONLY = 3'h7;

   // Prescaler counts that qualify a rise
   localparam logic [3:0] PRE4_LAST  = 4'h3;
   localparam logic [3:0] PRE16_LAST = 4'hF;

   localparam logic [CNT_W-1:0] FULL_CNT = 3'h4;

   // Bus answer state
   typedef enum logic [0:0] {BUS_IDLE, BUS_ANSWER} bus_state_t;
endpackage

//--- input_capture_channel.sv
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module input_capture_channel (
   input  wire logic                                 clk,
   input  wire logic                                 rst_n,
   input  wire logic                                 psel,
   input  wire logic                                 penable,
   input  wire logic                                 pwrite,
   input  wire logic [7:0]                           paddr,
   input  wire logic [31:0]                          pwdata,
   output logic [31:0]                               prdata,
   output logic                                      pready,
   output logic                                      pslverr,
   input  wire logic [capture_pkg::NUM_CH-1:0]       cap_pin,
   input  wire logic [capture_pkg::DATA_W-1:0]       timebase_a,
   input  wire logic [capture_pkg::DATA_W-1:0]       timebase_b,
   input  wire logic                                 timebase_a_on,
   input  wire logic                                 timebase_b_on,
   input  wire logic                                 cpu_sleep,
   input  wire logic                                 cpu_idle,
   output logic                                      irq,
   output logic                                      wake_req
);
   import capture_pkg::*;

   typedef struct packed {
      logic [NUM_CH-1:0]                             sync1;
      logic [NUM_CH-1:0]                             sync2;
      logic [NUM_CH-1:0]                             prev;
      logic [NUM_CH-1:0]                             tbsel;
      logic [NUM_CH-1:0]                             sidl;
      logic [NUM_CH-1:0][1:0]                        epi;
      logic [NUM_CH-1:0][2:0]                        mode;
      logic [NUM_CH-1:0][FIFO_DEPTH-1:0][DATA_W-1:0] fifo;
      logic [NUM_CH-1:0][CNT_W-1:0]                  cnt;
      logic [NUM_CH-1:0]                             ovf;
      logic [NUM_CH-1:0][1:0]                        evcnt;
      logic [NUM_CH-1:0][3:0]                        pre;
      logic [NUM_CH-1:0]                             ifs;
      logic [NUM_CH-1:0]                             iec;
      bus_state_t                                    bus;
      logic [31:0]                                   prdata;
      logic                                          pslverr;
      logic                                          irq;
      logic                                          wake;
   } cap_state_t;

   cap_state_t        s_r;
   cap_state_t        s_nxt;
   logic [NUM_CH-1:0] rise_v;
   logic [NUM_CH-1:0] fall_v;
   logic [NUM_CH-1:0] pop_v;
   logic              done;

   // Address of a per-channel register
   function automatic logic [7:0] ch_addr(input logic [7:0] base,
                                          input int        ch);
      ch_addr = base + {3'h0, ch[2:0], 2'b00};
   endfunction

   // Channel index of an address within a block, or -1
   function automatic int ch_hit(input logic [7:0] base,
                                 input logic [7:0] a);
      ch_hit = -1;
      for (int i = 0; i < NUM_CH; i++) begin
         if (a == ch_addr(base, i)) begin
            ch_hit = i;
         end
      end
   endfunction

   // Edges are taken from the second sync stage against the third
   assign rise_v = s_r.sync2 & ~s_r.prev;
   assign fall_v = ~s_r.sync2 & s_r.prev;
   // Completion edge: the master samples pready high here
   assign done = psel & penable & (s_r.bus == BUS_ANSWER);

   // Buffer reads pop only at the completion edge
   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         pop_v[i] = done & ~pwrite & (paddr == ch_addr(BUF_BASE, i)) &
                    (s_r.cnt[i] != '0);
      end
   end

   // Whole next state
   always_comb begin
      logic [NUM_CH-1:0] set_v;
      logic [NUM_CH-1:0] wake_v;
      logic              ev;
      logic              int_only;
      logic              halted;
      logic              tb_on;
      logic [CNT_W-1:0]  c;
      logic [DATA_W-1:0] tv;
      int                ci;
      int                bi;
      set_v    = '0;
      wake_v   = '0;
      ev       = 1'b0;
      int_only = 1'b0;
      halted   = 1'b0;
      tb_on    = 1'b0;
      c        = '0;
      tv       = '0;
      ci       = ch_hit(CTRL_BASE, paddr);
      bi       = ch_hit(BUF_BASE, paddr);
      s_nxt    = s_r;
      s_nxt.sync1 = cap_pin;
      s_nxt.sync2 = s_r.sync1;
      s_nxt.prev  = s_r.sync2;

      // Control writes at the completion edge
      if (done && pwrite && ci >= 0) begin
         s_nxt.mode[ci]  = pwdata[MODE_LSB +: 3];
         s_nxt.epi[ci]   = pwdata[EPI_LSB +: 2];
         s_nxt.tbsel[ci] = pwdata[TBSEL_BIT];
         s_nxt.sidl[ci]  = pwdata[SIDL_BIT];
         s_nxt.pre[ci]   = '0;
         s_nxt.evcnt[ci] = '0;
      end
      if (done && pwrite && paddr == IEC_OFS) begin
         s_nxt.iec = pwdata[NUM_CH-1:0];
      end

      for (int i = 0; i < NUM_CH; i++) begin
         // Event qualification by mode
         case (s_r.mode[i])
            MODE_EVERY:    ev = rise_v[i] | fall_v[i];
            MODE_FALL:     ev = fall_v[i];
            MODE_RISE:     ev = rise_v[i];
            MODE_INT_ONLY: ev = rise_v[i];
            MODE_RISE4:    ev = rise_v[i] & (s_r.pre[i] == PRE4_LAST);
            MODE_RISE16:   ev = rise_v[i] & (s_r.pre[i] == PRE16_LAST);
            default:       ev = 1'b0;
         endcase
         tb_on = s_r.tbsel[i] ? timebase_b_on : timebase_a_on;
         // Idle keeps capturing only with timer on and stop-in-idle low
         halted   = cpu_idle & (s_r.sidl[i] | ~tb_on);
         int_only = cpu_sleep |
                    (cpu_idle & (s_r.mode[i] == MODE_INT_ONLY));
         if (!cpu_sleep && rise_v[i] && !halted &&
             (s_r.mode[i] == MODE_RISE4 || s_r.mode[i] == MODE_RISE16)) begin
            s_nxt.pre[i] = s_r.pre[i] + 4'h1;
         end

         // Pop first so a same-cycle capture lands behind the survivors
         c = s_r.cnt[i];
         if (pop_v[i]) begin
            for (int k = 0; k < FIFO_DEPTH - 1; k++) begin
               s_nxt.fifo[i][k] = s_r.fifo[i][k+1];
            end
            c = c - 3'h1;
         end
         tv = s_r.tbsel[i] ? timebase_b : timebase_a;

         if (int_only) begin
            // Sleep or idle pin interrupt: no store, no event count
            if (ev && s_r.mode[i] == MODE_INT_ONLY) begin
               set_v[i]  = 1'b1;
               wake_v[i] = s_r.iec[i];
            end
         end else if (ev && !halted) begin
            wake_v[i] = cpu_idle & s_r.iec[i];
            if (s_r.mode[i] == MODE_EVERY) begin
               // Full buffer drops silently, no overflow here
               if (c != FULL_CNT) begin
                  s_nxt.fifo[i][c[1:0]] = tv;
                  c = c + 3'h1;
               end
               set_v[i] = 1'b1;
            end else if (s_r.ovf[i]) begin
               // Locked out until drained
               c = c;
            end else if (c == FULL_CNT) begin
               s_nxt.ovf[i] = 1'b1;
            end else begin
               s_nxt.fifo[i][c[1:0]] = tv;
               c = c + 3'h1;
               if (s_r.evcnt[i] == s_r.epi[i]) begin
                  set_v[i]       = 1'b1;
                  s_nxt.evcnt[i] = '0;
               end else begin
                  s_nxt.evcnt[i] = s_r.evcnt[i] + 2'h1;
               end
            end
         end
         s_nxt.cnt[i] = c;
         if (pop_v[i] && c == '0) begin
            s_nxt.ovf[i] = 1'b0;
         end
      end

      // Flags: write one to clear, but a new event wins
      if (done && pwrite && paddr == IFS_OFS) begin
         s_nxt.ifs = s_r.ifs & ~pwdata[NUM_CH-1:0];
      end
      s_nxt.ifs  = s_nxt.ifs | set_v;
      s_nxt.irq  = |(s_nxt.ifs & s_nxt.iec);
      s_nxt.wake = |wake_v;

      // APB: one wait state so read data leaves a flop
      s_nxt.bus     = BUS_IDLE;
      s_nxt.prdata  = '0;
      s_nxt.pslverr = 1'b0;
      if (psel && penable && s_r.bus == BUS_IDLE) begin
         s_nxt.bus = BUS_ANSWER;
         if (ci >= 0) begin
            s_nxt.prdata[MODE_LSB +: 3] = s_r.mode[ci];
            s_nxt.prdata[BFNE_BIT]      = (s_r.cnt[ci] != '0);
            s_nxt.prdata[OVF_BIT]       = s_r.ovf[ci];
            s_nxt.prdata[EPI_LSB +: 2]  = s_r.epi[ci];
            s_nxt.prdata[TBSEL_BIT]     = s_r.tbsel[ci];
            s_nxt.prdata[SIDL_BIT]      = s_r.sidl[ci];
         end else if (bi >= 0) begin
            // Head entry; undefined content when empty
            s_nxt.prdata[DATA_W-1:0] = s_r.fifo[bi][0];
         end else if (paddr == IFS_OFS) begin
            s_nxt.prdata[NUM_CH-1:0] = s_r.ifs;
         end else if (paddr == IEC_OFS) begin
            s_nxt.prdata[NUM_CH-1:0] = s_r.iec;
         end else begin
            s_nxt.pslverr = 1'b1;
         end
      end
      if (done) begin
         s_nxt.bus = BUS_IDLE;
      end
   end

   // State register; timebase select defaults to the second source
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r       <= '0;
         s_r.tbsel <= {NUM_CH{TBSEL_RST}};
         s_r.mode  <= {NUM_CH{MODE_RST}};
         s_r.epi   <= {NUM_CH{EPI_RST}};
         s_r.bus   <= BUS_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from the state flops
   assign prdata   = s_r.prdata;
   assign pready   = (s_r.bus == BUS_ANSWER);
   assign pslverr  = s_r.pslverr;
   assign irq      = s_r.irq;
   assign wake_req = s_r.wake;

   property p_tbsel_rst;
      @(posedge clk) $rose(rst_n) |-> (s_r.tbsel == {NUM_CH{TBSEL_RST}});
   endproperty
   a_tbsel_rst: assert property (p_tbsel_rst)
      else $error("timebase select not at second source after reset");

   property p_irq;
      @(posedge clk) disable iff (!rst_n)
         s_r.irq == |(s_r.ifs & s_r.iec);
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt output disagrees with flags and enables");

   // One wait state only: ready never stands two cycles
   property p_one_wait;
      @(posedge clk) disable iff (!rst_n)
         pready |=> !pready;
   endproperty
   a_one_wait: assert property (p_one_wait)
      else $error("ready held longer than one cycle");

   generate
      for (genvar g = 0; g < NUM_CH; g++) begin : g_chk
         property p_depth;
            @(posedge clk) disable iff (!rst_n) s_r.cnt[g] <= FULL_CNT;
         endproperty
         a_depth: assert property (p_depth)
            else $error("buffer count above depth");

         property p_bfne;
            @(posedge clk) disable iff (!rst_n)
               s_r.cnt[g] == '0 ##1 s_r.cnt[g] != '0 |->
               $past(rise_v[g] | fall_v[g]);
         endproperty
         a_bfne: assert property (p_bfne)
            else $error("buffer filled without a pin edge");

         property p_order;
            @(posedge clk) disable iff (!rst_n)
               pop_v[g] && s_r.cnt[g] > 3'h1 |=>
               s_r.fifo[g][0] == $past(s_r.fifo[g][1]);
         endproperty
         a_order: assert property (p_order)
            else $error("read did not advance buffer");

         property p_ovf;
            @(posedge clk) disable iff (!rst_n)
               $rose(s_r.ovf[g]) |-> $past(s_r.cnt[g]) == FULL_CNT &&
               s_r.cnt[g] == FULL_CNT;
         endproperty
         a_ovf: assert property (p_ovf)
            else $error("overflow without full buffer or capture stored");

         property p_lock;
            @(posedge clk) disable iff (!rst_n)
               s_r.ovf[g] && !pop_v[g] |=> s_r.cnt[g] == $past(s_r.cnt[g]);
         endproperty
         a_lock: assert property (p_lock)
            else $error("capture stored while locked by overflow");

         property p_every;
            @(posedge clk) disable iff (!rst_n)
               s_r.mode[g] == MODE_EVERY && !cpu_sleep && !cpu_idle &&
               (rise_v[g] | fall_v[g]) |=> s_r.ifs[g] ##0 !s_r.ovf[g] ||
               $past(s_r.ovf[g]);
         endproperty
         a_every: assert property (p_every)
            else $error("every-edge capture missed flag or overflowed");

         property p_wake;
            @(posedge clk) disable iff (!rst_n)
               cpu_sleep && s_r.mode[g] == MODE_INT_ONLY && s_r.iec[g] &&
               rise_v[g] |=> wake_req && s_r.ifs[g] &&
               (s_r.cnt[g] == $past(s_r.cnt[g]) || $past(pop_v[g]));
         endproperty
         a_wake: assert property (p_wake)
            else $error("sleep pin edge did not wake or stored a value");

         // Power-state guards: a channel stopped by stop-in-idle, in idle interrupt-only mode, or sleeping never grows
         property p_halt;
            @(posedge clk) disable iff (!rst_n)
               cpu_idle && !cpu_sleep && s_r.sidl[g] |=>
               s_r.cnt[g] <= $past(s_r.cnt[g]);
         endproperty
         a_halt: assert property (p_halt)
            else $error("capture stored while halted in idle");

         property p_idle_int;
            @(posedge clk) disable iff (!rst_n)
               cpu_idle && s_r.mode[g] == MODE_INT_ONLY && rise_v[g] &&
               !pop_v[g] |=> s_r.ifs[g] && s_r.cnt[g] == $past(s_r.cnt[g]);
         endproperty
         a_idle_int: assert property (p_idle_int)
            else $error("idle pin interrupt stored a value or set no flag");

         property p_sleep_store;
            @(posedge clk) disable iff (!rst_n)
               cpu_sleep && !pop_v[g] |=>
               s_r.cnt[g] == $past(s_r.cnt[g]);
         endproperty
         a_sleep_store: assert property (p_sleep_store)
            else $error("capture stored during sleep");
      end
   endgenerate
endmodule
`default_nettype wire

//--- tb_input_capture_channel.sv
`timescale 1ns/100ps
`default_nettype none
module tb_input_capture_channel;
   import capture_pkg::*;
   logic              clk = 1'b0;
   logic              rst_n = 1'b0;
   logic              psel = 1'b0;
   logic              penable = 1'b0;
   logic              pwrite = 1'b0;
   logic [7:0]        paddr = 8'h00;
   logic [31:0]       pwdata = 32'h0;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   logic [NUM_CH-1:0] cap_pin;
   logic [15:0]       tba = 16'h0000;
   logic [15:0]       tbb = 16'h0000;
   logic              a_on = 1'b1;
   logic              b_on = 1'b1;
   logic              slp = 1'b0;
   logic              idl = 1'b0;
   logic              irq;
   logic              wake_req;
   int                n_fail = 0;
   int                total_checks = 0;
   int                n_wake = 0;
   logic [31:0]       r;
   logic              e;

   // Free-running 20 MHz clock
   always #25 clk = ~clk;

   input_capture_channel dut_u (.clk(clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cap_pin(cap_pin), .timebase_a(tba), .timebase_b(tbb),
      .timebase_a_on(a_on), .timebase_b_on(b_on), .cpu_sleep(slp),
      .cpu_idle(idl), .irq(irq), .wake_req(wake_req));

   cap_source src_u (.clk(clk), .cap_pin(cap_pin));

   // Wake is a one-cycle pulse, so count it at every edge
   always @(posedge clk) begin
      if (wake_req === 1'b1) n_wake <= n_wake + 1;
   end

   task automatic test_done;
      $display("checks %0d fails %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Setup, then access held until pready is seen at an edge
   task automatic apb(input logic wr_en, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic er);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr_en;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (k == 20) begin
         n_fail++;
         test_done();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, r, e);
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0, r, e);
      chk(r, exp);
   endtask

   // Main sequence; software never reads an empty buffer
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      rchk(CTRL_BASE, 32'h00000080);
      rchk(CTRL_BASE + 8'h1C, 32'h00000080);
      wr(IEC_OFS, 32'h1);
      wr(CTRL_BASE, 32'h3);
      for (int i = 0; i < 5; i++) begin
         tba <= 16'h1000 + 16'(i);
         src_u.pulse(0);
         if (i == 0) rchk(CTRL_BASE, 32'h0000000B);
      end
      rchk(CTRL_BASE, 32'h0000001B);
      chk({31'h0, irq}, 32'h1);
      rchk(BUF_BASE, 32'h00001000);
      tba <= 16'h2000;
      src_u.pulse(0);
      for (int i = 1; i < 4; i++) rchk(BUF_BASE, 32'h1000 + i);
      rchk(CTRL_BASE, 32'h00000003);
      wr(IFS_OFS, 32'h1);
      rchk(IFS_OFS, 32'h0);
      chk({31'h0, irq}, 32'h0);
      // Masked channel still flags but keeps irq low
      wr(IEC_OFS, 32'h0);
      tba <= 16'h3000;
      src_u.pulse(0);
      rchk(IFS_OFS, 32'h1);
      chk({31'h0, irq}, 32'h0);
      rchk(BUF_BASE, 32'h00003000);
      wr(IFS_OFS, 32'h1);
      // Every-edge mode on the second timebase
      wr(CTRL_BASE + 8'h04, 32'h81);
      for (int i = 0; i < 3; i++) begin
         tbb <= 16'h0ABC + 16'(i);
         src_u.pulse(1);
      end
      rchk(CTRL_BASE + 8'h04, 32'h00000089);
      rchk(IFS_OFS, 32'h2);
      for (int i = 0; i < 4; i++) rchk(BUF_BASE + 8'h04, 32'h0ABC + i / 2);
      wr(IFS_OFS, 32'h2);
      // Flag every second capture
      wr(CTRL_BASE + 8'h08, 32'h23);
      src_u.pulse(2);
      rchk(IFS_OFS, 32'h0);
      src_u.pulse(2);
      rchk(IFS_OFS, 32'h4);
      repeat (2) rchk(BUF_BASE + 8'h08, 32'h3000);
      // Falling-edge mode, then capture on the 4th rise and on the 16th rise
      wr(CTRL_BASE + 8'h10, 32'h2);
      src_u.pulse(4);
      rchk(BUF_BASE + 8'h10, 32'h3000);
      wr(CTRL_BASE + 8'h14, 32'h4);
      repeat (3) src_u.pulse(5);
      rchk(CTRL_BASE + 8'h14, 32'h00000004);
      src_u.pulse(5);
      rchk(CTRL_BASE + 8'h14, 32'h0000000C);
      wr(CTRL_BASE + 8'h18, 32'h5);
      repeat (15) src_u.pulse(6);
      rchk(CTRL_BASE + 8'h18, 32'h00000005);
      src_u.pulse(6);
      rchk(CTRL_BASE + 8'h18, 32'h0000000D);
      wr(IFS_OFS, 32'h70);
      // Idle keeps storing unless stop-in-idle is set
      idl <= 1'b1;
      src_u.pulse(2);
      rchk(CTRL_BASE + 8'h08, 32'h0000002B);
      wr(CTRL_BASE + 8'h08, 32'h2023);
      src_u.pulse(2);
      rchk(CTRL_BASE + 8'h08, 32'h0000202B);
      rchk(BUF_BASE + 8'h08, 32'h3000);
      // Idle with its own timer stopped halts; the other timer stays on
      wr(CTRL_BASE + 8'h08, 32'h23);
      a_on <= 1'b0;
      src_u.pulse(2);
      rchk(CTRL_BASE + 8'h08, 32'h00000023);
      a_on <= 1'b1;
      wr(IFS_OFS, 32'h4);
      // Interrupt-only mode wakes from idle and sleep, storing nothing
      wr(IEC_OFS, 32'h8);
      wr(CTRL_BASE + 8'h0C, 32'h7);
      src_u.pulse(3);
      rchk(CTRL_BASE + 8'h0C, 32'h00000007);
      rchk(IFS_OFS, 32'h8);
      chk(32'(n_wake), 32'h1);
      wr(IFS_OFS, 32'h8);
      idl <= 1'b0;
      slp <= 1'b1;
      a_on <= 1'b0;
      b_on <= 1'b0;
      src_u.pulse(3);
      chk(32'(n_wake), 32'h2);
      rchk(IFS_OFS, 32'h8);
      chk({31'h0, irq}, 32'h1);
      rchk(CTRL_BASE + 8'h0C, 32'h00000007);
      // Rising-edge mode does nothing in sleep
      src_u.pulse(2);
      rchk(CTRL_BASE + 8'h08, 32'h00000023);
      chk(32'(n_wake), 32'h2);
      // Unmapped place answers with an error and zero data
      apb(1'b0, 8'h80, 32'h0, r, e);
      chk(r, 32'h0);
      chk({31'h0, e}, 32'h1);
      test_done();
   end
endmodule
`default_nettype wire
